//--- adc_acc_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Opcodes 08H and 09H add the accumulator or second data register plus carry to the accumulator in 2 cycles.
// - Both interrupt-level flags are left as they were while negative, overflow, carry and zero follow the result.
// - The decimal flag selects decimal addition, with unpack also set an unpacked-digit addition, both kept as is.
// - Opcode 0DH with low then high address byte adds the addressed byte plus carry in 4 cycles.
// - In banked models the absolute and pair-pointer forms take their page from the expand page register.
// - Opcode 0BH adds the byte addressed by the pair pointer plus carry in 2 cycles.
// - Opcodes 0EH and 0FH add the byte addressed by the first or second index register plus carry in 2 cycles.
// - In banked models index forms take the page of whichever index register is used.
// - Prefix CEH then 08H or 09H then a displacement adds the byte at index plus displacement in 4 cycles.
// - The displacement is sign-extended before it is added to the index register.
// - Prefix CEH then 0AH or 0BH adds the byte at index plus low pointer byte in 4 cycles.
// - The low pointer byte is sign-extended before it is added to the index register.
module adc_acc_unit (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] pc_in,
  input wire logic banked,
  input wire adc_pkg::adc_regs_t regs_in,
  input wire logic [7:0] bus_rdata,
  output logic [15:0] bus_addr_ff,
  output logic [7:0] bus_page_ff,
  output logic bus_rd_ff,
  output logic bus_data_ff,
  output logic busy_ff,
  output logic done_ff,
  output logic wr_ff,
  output logic illegal_ff,
  output logic [7:0] res_acc_ff,
  output adc_pkg::adc_flags_t res_flags_ff,
  output logic [15:0] pc_ff,
  output logic [3:0] len_ff
);
  import adc_pkg::*;

  adc_state_t state_ff, nxt_state;
  adc_kind_t kind_ff, nxt_kind;
  adc_regs_t snap_ff;
  logic sel_y_ff, nxt_sel_y;
  logic [7:0] opnd_ff, nxt_opnd;
  logic [7:0] lo_ff, nxt_lo;
  logic [15:0] nxt_addr, nxt_pc;
  logic [7:0] nxt_page;
  logic nxt_rd, nxt_data, nxt_finish, nxt_illegal;
  logic [3:0] cnt_ff;

  // Decode of the byte on the bus in the current cycle
  wire accept = start && !busy_ff;
  wire op_reg = (bus_rdata == OP_ADC_A_A) || (bus_rdata == OP_ADC_A_B);
  wire op_idx = (bus_rdata == OP_ADC_IDX1) || (bus_rdata == OP_ADC_IDX2);
  wire sub_disp = (bus_rdata == SUB_DISP1) || (bus_rdata == SUB_DISP2);
  wire sub_lofs = (bus_rdata == SUB_LOFS1) || (bus_rdata == SUB_LOFS2);
  wire [15:0] idx_sel = sel_y_ff ? snap_ff.second_index_reg : snap_ff.first_index_reg;
  wire [7:0] idx_page_sel = sel_y_ff ? snap_ff.second_index_page : snap_ff.first_index_page;
  // Page registers only matter on banked models; flat models see page zero
  wire [7:0] ep_page = banked ? snap_ff.expand_page_data : PAGE_FLAT;
  wire [7:0] ix_page = banked ? idx_page_sel : PAGE_FLAT;
  wire [7:0] op_idx_page = banked ? (bus_rdata[0] ? snap_ff.second_index_page : snap_ff.first_index_page) : PAGE_FLAT;
  wire [15:0] op_idx_addr = bus_rdata[0] ? snap_ff.second_index_reg : snap_ff.first_index_reg;
  wire [15:0] disp_addr = idx_sel + {{8{bus_rdata[7]}}, bus_rdata};
  wire [15:0] lofs_addr = idx_sel + {{8{snap_ff.ptr_low[7]}}, snap_ff.ptr_low};
  wire [7:0] alu_b = (state_ff == ST_READ) ? bus_rdata : opnd_ff;

  // Adder for binary, packed decimal and unpacked digit modes
  logic [8:0] bsum;
  logic [4:0] dlo, dlo_adj, dhi, dhi_adj;
  logic lc, hc;
  logic [7:0] alu_r;
  logic alu_c, alu_v;
  always_comb begin
    bsum = {1'b0, snap_ff.acc} + {1'b0, alu_b} + {8'h00, snap_ff.system_condition_flags.carry};
    dlo = {1'b0, snap_ff.acc[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, snap_ff.system_condition_flags.carry};
    lc = dlo > BCD_MAX;
    dlo_adj = lc ? dlo + BCD_ADJ : dlo;
    dhi = {1'b0, snap_ff.acc[7:4]} + {1'b0, alu_b[7:4]} + {4'h0, lc};
    hc = dhi > BCD_MAX;
    dhi_adj = hc ? dhi + BCD_ADJ : dhi;
    alu_r = bsum[7:0];
    alu_c = bsum[8];
    alu_v = (snap_ff.acc[7] == alu_b[7]) && (bsum[7] != snap_ff.acc[7]);
    if (snap_ff.system_condition_flags.decimal) begin
      alu_v = 1'b0;
      if (snap_ff.system_condition_flags.unpack) begin
        alu_r = {4'h0, dlo_adj[3:0]};
        alu_c = lc;
      end else begin
        alu_r = {dhi_adj[3:0], dlo_adj[3:0]};
        alu_c = hc;
      end
    end
  end

  // Sequencer: one bus cycle per clock, read data valid in the cycle it is addressed
  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_sel_y = sel_y_ff;
    nxt_opnd = opnd_ff;
    nxt_lo = lo_ff;
    nxt_addr = bus_addr_ff;
    nxt_page = bus_page_ff;
    nxt_pc = pc_ff;
    nxt_rd = 1'b0;
    nxt_data = 1'b0;
    nxt_finish = 1'b0;
    nxt_illegal = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_OP;
          nxt_kind = K_NONE;
          nxt_addr = pc_in;
          nxt_page = PAGE_FLAT;
          nxt_pc = pc_in + 16'h0001;
          nxt_rd = 1'b1;
        end
      end
      ST_OP: begin
        nxt_sel_y = bus_rdata[0];
        if (op_reg) begin
          nxt_kind = K_REG;
          nxt_opnd = bus_rdata[0] ? snap_ff.data_b : snap_ff.acc;
          nxt_state = ST_EXEC;
        end else if (bus_rdata == OP_ADC_PAIR) begin
          // Pair pointer read with expand page
          nxt_kind = K_PAIR;
          nxt_addr = {snap_ff.ptr_high, snap_ff.ptr_low};
          nxt_page = ep_page;
          nxt_rd = 1'b1;
          nxt_data = 1'b1;
          nxt_state = ST_READ;
        end else if (op_idx) begin
          // Index read with its own page
          nxt_kind = K_IDX;
          nxt_addr = op_idx_addr;
          nxt_page = op_idx_page;
          nxt_rd = 1'b1;
          nxt_data = 1'b1;
          nxt_state = ST_READ;
        end else if (bus_rdata == OP_ADC_ABS || bus_rdata == OP_PREFIX) begin
          // Absolute and prefixed forms fetch another byte
          nxt_kind = (bus_rdata == OP_ADC_ABS) ? K_ABS : K_NONE;
          nxt_addr = pc_ff;
          nxt_pc = pc_ff + 16'h0001;
          nxt_rd = 1'b1;
          nxt_state = (bus_rdata == OP_ADC_ABS) ? ST_ARG1 : ST_SUB;
        end else begin
          nxt_illegal = 1'b1;
          nxt_finish = 1'b1;
        end
      end
      ST_SUB: begin
        nxt_sel_y = bus_rdata[0];
        if (sub_disp) begin
          nxt_kind = K_DISP;
          nxt_addr = pc_ff;
          nxt_pc = pc_ff + 16'h0001;
          nxt_rd = 1'b1;
          nxt_state = ST_ARG1;
        end else if (sub_lofs) begin
          // Spend one cycle forming the address
          nxt_kind = K_LOFS;
          nxt_state = ST_CALC;
        end else begin
          nxt_illegal = 1'b1;
          nxt_finish = 1'b1;
        end
      end
      ST_ARG1: begin
        nxt_rd = 1'b1;
        if (kind_ff == K_ABS) begin
          nxt_lo = bus_rdata;
          nxt_addr = pc_ff;
          nxt_pc = pc_ff + 16'h0001;
          nxt_state = ST_ARG2;
        end else begin
          // Displacement read on the index page
          nxt_addr = disp_addr;
          nxt_page = ix_page;
          nxt_data = 1'b1;
          nxt_state = ST_READ;
        end
      end
      ST_ARG2: begin
        // Absolute read on the expand page
        nxt_addr = {bus_rdata, lo_ff};
        nxt_page = ep_page;
        nxt_rd = 1'b1;
        nxt_data = 1'b1;
        nxt_state = ST_READ;
      end
      ST_CALC: begin
        // Register-offset read on the index page
        nxt_addr = lofs_addr;
        nxt_page = ix_page;
        nxt_rd = 1'b1;
        nxt_data = 1'b1;
        nxt_state = ST_READ;
      end
      ST_READ, ST_EXEC: begin
        nxt_finish = 1'b1;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (nxt_finish) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      kind_ff <= K_NONE;
      sel_y_ff <= 1'b0;
      opnd_ff <= 8'h00;
      lo_ff <= 8'h00;
      bus_addr_ff <= ADDR_RST;
      bus_page_ff <= PAGE_FLAT;
      bus_rd_ff <= 1'b0;
      bus_data_ff <= 1'b0;
      pc_ff <= ADDR_RST;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      sel_y_ff <= nxt_sel_y;
      opnd_ff <= nxt_opnd;
      lo_ff <= nxt_lo;
      bus_addr_ff <= nxt_addr;
      bus_page_ff <= nxt_page;
      bus_rd_ff <= nxt_rd;
      bus_data_ff <= nxt_data;
      pc_ff <= nxt_pc;
    end
  end

  // Register values are held from acceptance so the core may change its own copy meanwhile
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      snap_ff <= '0;
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end else begin
      if (accept) begin
        snap_ff <= regs_in;
      end
      busy_ff <= accept || (busy_ff && !nxt_finish);
      cnt_ff <= accept ? 4'h0 : cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      wr_ff <= 1'b0;
      illegal_ff <= 1'b0;
      res_acc_ff <= 8'h00;
      res_flags_ff <= '0;
      len_ff <= 4'h0;
    end else begin
      done_ff <= nxt_finish;
      wr_ff <= nxt_finish && !nxt_illegal;
      illegal_ff <= nxt_illegal;
      if (nxt_finish) begin
        len_ff <= cnt_ff + 4'h1;
      end
      if (nxt_finish && !nxt_illegal) begin
        res_acc_ff <= alu_r;
        // Interrupt levels and mode bits pass through untouched
        res_flags_ff <= {snap_ff.system_condition_flags.il_high, snap_ff.system_condition_flags.il_low,
                         snap_ff.system_condition_flags.unpack, snap_ff.system_condition_flags.decimal,
                         alu_r[7], alu_v, alu_c, alu_r == 8'h00};
      end
    end
  end

  sequence s_accept;
    start && !busy_ff;
  endsequence
  sequence s_done_kind(adc_kind_t k);
    done_ff && kind_ff == k;
  endsequence

  chk_first_fetch: assert property (@(posedge clock) disable iff (rst)
    s_accept |=> bus_rd_ff && !bus_data_ff && bus_addr_ff == $past(pc_in)) else $error("opcode fetch not issued");
  chk_reg_len: assert property (@(posedge clock) disable iff (rst)
    s_done_kind(K_REG) |-> wr_ff && len_ff == LEN_REG) else $error("register form length wrong");
  chk_il_kept: assert property (@(posedge clock) disable iff (rst)
    wr_ff |-> res_flags_ff.il_high == snap_ff.system_condition_flags.il_high
      && res_flags_ff.il_low == snap_ff.system_condition_flags.il_low) else $error("interrupt level changed");
  chk_mode_kept: assert property (@(posedge clock) disable iff (rst)
    wr_ff |-> res_flags_ff.unpack == snap_ff.system_condition_flags.unpack
      && res_flags_ff.decimal == snap_ff.system_condition_flags.decimal) else $error("mode bits changed");
  chk_abs_len: assert property (@(posedge clock) disable iff (rst)
    s_done_kind(K_ABS) |-> len_ff == LEN_ABS) else $error("absolute form length wrong");
  chk_ep_page: assert property (@(posedge clock) disable iff (rst)
    state_ff == ST_READ && (kind_ff == K_ABS || kind_ff == K_PAIR) |-> bus_page_ff == ep_page)
    else $error("expand page not used");
  chk_ind_len: assert property (@(posedge clock) disable iff (rst)
    s_done_kind(K_PAIR) or s_done_kind(K_IDX) |-> len_ff == LEN_IND) else $error("indirect form length wrong");
  chk_idx_page: assert property (@(posedge clock) disable iff (rst)
    state_ff == ST_READ && kind_ff inside {K_IDX, K_DISP, K_LOFS} |-> bus_page_ff == ix_page)
    else $error("index page not used");
  chk_pfx_len: assert property (@(posedge clock) disable iff (rst)
    s_done_kind(K_DISP) or s_done_kind(K_LOFS) |-> len_ff == LEN_PFX) else $error("prefixed form length wrong");
  chk_disp_sext: assert property (@(posedge clock) disable iff (rst)
    state_ff == ST_ARG1 && kind_ff == K_DISP |=> bus_addr_ff == $past(idx_sel) + {{8{$past(bus_rdata[7])}},
      $past(bus_rdata)}) else $error("displacement not sign extended");
  chk_lofs_sext: assert property (@(posedge clock) disable iff (rst)
    state_ff == ST_READ && kind_ff == K_LOFS |-> bus_addr_ff == lofs_addr) else $error("low pointer offset wrong");
  chk_zero_flag: assert property (@(posedge clock) disable iff (rst)
    wr_ff |-> res_flags_ff.zero == (res_acc_ff == 8'h00) && res_flags_ff.negative == res_acc_ff[7])
    else $error("zero or negative flag wrong");
  chk_unpack_hi: assert property (@(posedge clock) disable iff (rst)
    wr_ff && res_flags_ff.decimal && res_flags_ff.unpack |-> res_acc_ff[7:4] == 4'h0) else $error("unpacked digit high");
endmodule : adc_acc_unit

//--- adc_pkg.sv
package adc_pkg;
  localparam logic [7:0] OP_ADC_A_A = 8'h08;
  localparam logic [7:0] OP_ADC_A_B = 8'h09;
  localparam logic [7:0] OP_ADC_PAIR = 8'h0B;
  localparam logic [7:0] OP_ADC_ABS = 8'h0D;
  localparam logic [7:0] OP_ADC_IDX1 = 8'h0E;
  localparam logic [7:0] OP_ADC_IDX2 = 8'h0F;
  localparam logic [7:0] OP_PREFIX = 8'hCE;
  localparam logic [7:0] SUB_DISP1 = 8'h08;
  localparam logic [7:0] SUB_DISP2 = 8'h09;
  localparam logic [7:0] SUB_LOFS1 = 8'h0A;
  localparam logic [7:0] SUB_LOFS2 = 8'h0B;

  localparam logic [3:0] LEN_REG = 4'h2;
  localparam logic [3:0] LEN_IND = 4'h2;
  localparam logic [3:0] LEN_ABS = 4'h4;
  localparam logic [3:0] LEN_PFX = 4'h4;

  localparam logic [4:0] BCD_MAX = 5'h09;
  localparam logic [4:0] BCD_ADJ = 5'h06;
  localparam logic [7:0] PAGE_FLAT = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OP = 3'b001,
    ST_SUB = 3'b011,
    ST_ARG1 = 3'b010,
    ST_ARG2 = 3'b110,
    ST_CALC = 3'b111,
    ST_READ = 3'b101,
    ST_EXEC = 3'b100
  } adc_state_t;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_REG = 3'h1,
    K_PAIR = 3'h2,
    K_IDX = 3'h3,
    K_ABS = 3'h4,
    K_DISP = 3'h5,
    K_LOFS = 3'h6
  } adc_kind_t;

  typedef struct packed {
    logic il_high;
    logic il_low;
    logic unpack;
    logic decimal;
    logic negative;
    logic overflow;
    logic carry;
    logic zero;
  } adc_flags_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] data_b;
    logic [7:0] ptr_low;
    logic [7:0] ptr_high;
    logic [15:0] first_index_reg;
    logic [15:0] second_index_reg;
    logic [7:0] expand_page_data;
    logic [7:0] first_index_page;
    logic [7:0] second_index_page;
    adc_flags_t system_condition_flags;
  } adc_regs_t;
endpackage : adc_pkg

//--- adc_mem_model.sv
`timescale 1ns/1ps
module adc_mem_model (
  input wire logic clock,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_page,
  input wire logic bus_rd,
  input wire logic bus_data,
  output logic [7:0] rdata
);
  logic [7:0] prog [logic [15:0]];
  logic [7:0] last_ff;
  logic [15:0] last_daddr;
  logic [7:0] last_dpage;
  int n_dreads;

  // Data bytes depend on page and address, so a wrong page gives a wrong sum
  function automatic logic [7:0] data_of(input logic [7:0] pg, input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ {pg[3:0], pg[7:4]} ^ 8'h5A;
  endfunction : data_of

  // Outside a read the bus shows the inverse of the last byte, never a stale copy
  always_comb begin
    if (!bus_rd) begin
      rdata = ~last_ff;
    end else if (bus_data) begin
      rdata = data_of(bus_page, bus_addr);
    end else begin
      rdata = prog.exists(bus_addr) ? prog[bus_addr] : 8'hFF;
    end
  end

  initial begin
    last_ff = 8'h00;
    n_dreads = 0;
  end

  always @(posedge clock) begin
    if (bus_rd) begin
      last_ff <= rdata;
      if (bus_data) begin
        last_daddr <= bus_addr;
        last_dpage <= bus_page;
        n_dreads <= n_dreads + 1;
      end
    end
  end
endmodule : adc_mem_model

//--- add_with_carry_to_accumulator_test.sv
`timescale 1ns/1ps
module add_with_carry_to_accumulator_test;
  import adc_pkg::*;
  logic clock, rst, start, banked;
  logic [15:0] pc_in, pc, bus_addr_ff, pc_ff;
  adc_regs_t regs;
  logic [7:0] bus_rdata, bus_page_ff, res_acc_ff, last_acc;
  logic bus_rd_ff, bus_data_ff, busy_ff, done_ff, wr_ff, illegal_ff;
  adc_flags_t res_flags_ff;
  logic [3:0] len_ff;
  int n_errors, cmp_count;
  logic [7:0] ta [7] = '{8'h18, 8'h18, 8'h30, 8'h30, 8'h30, 8'h18, 8'h18};
  logic [7:0] tb [7] = '{8'h25, 8'h25, 8'hD0, 8'hF0, 8'h50, 8'h25, 8'h25};
  logic [7:0] tr [7] = '{8'h3D, 8'h3E, 8'h00, 8'h20, 8'h80, 8'h44, 8'h04};
  logic [3:0] tf [7] = '{4'h0, 4'h0, 4'h3, 4'h2, 4'hC, 4'h0, 4'h2};
  logic [2:0] tm [7] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h3, 3'h7};

  adc_acc_unit DUT (.clock(clock), .rst(rst), .start(start), .pc_in(pc_in), .banked(banked),
    .regs_in(regs), .bus_rdata(bus_rdata), .bus_addr_ff(bus_addr_ff), .bus_page_ff(bus_page_ff),
    .bus_rd_ff(bus_rd_ff), .bus_data_ff(bus_data_ff), .busy_ff(busy_ff), .done_ff(done_ff),
    .wr_ff(wr_ff), .illegal_ff(illegal_ff), .res_acc_ff(res_acc_ff), .res_flags_ff(res_flags_ff),
    .pc_ff(pc_ff), .len_ff(len_ff));
  adc_mem_model mem (.clock(clock), .bus_addr(bus_addr_ff), .bus_page(bus_page_ff),
    .bus_rd(bus_rd_ff), .bus_data(bus_data_ff), .rdata(bus_rdata));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  function automatic logic [15:0] adc_ref(input logic [7:0] a, input logic [7:0] b, input adc_flags_t f);
    logic [8:0] s;
    logic [4:0] lo, hi;
    logic [7:0] r;
    logic c, v;
    s = a + b + f.carry;
    r = s[7:0];
    c = s[8];
    v = (a[7] == b[7]) && (r[7] != a[7]);
    if (f.decimal) begin
      lo = a[3:0] + b[3:0] + f.carry;
      v = 1'b0;
      if (f.unpack) begin
        c = lo > 5'h09;
        r = {4'h0, c ? lo[3:0] + 4'h6 : lo[3:0]};
      end else begin
        if (lo > 5'h09) lo = lo + 5'h06;
        hi = a[7:4] + b[7:4] + lo[4];
        c = hi > 5'h09;
        if (c) hi = hi + 5'h06;
        r = {hi[3:0], lo[3:0]};
      end
    end
    f.negative = r[7];
    f.overflow = v;
    f.carry = c;
    f.zero = r == 8'h00;
    return {r, f};
  endfunction : adc_ref

  // Called on a falling edge where busy is low; returns on the falling edge inside the done cycle
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int nb,
                     input int edges, input logic use_mem, input logic [15:0] da, input logic [7:0] dp,
                     input logic bad);
    int c;
    int nd;
    logic [7:0] src;
    logic [15:0] e;
    mem.prog[pc] = b0;
    mem.prog[pc + 16'h1] = b1;
    mem.prog[pc + 16'h2] = b2;
    nd = mem.n_dreads;
    src = use_mem ? mem.data_of(dp, da) : (b0 == OP_ADC_A_A ? regs.acc : regs.data_b);
    e = adc_ref(regs.acc, src, regs.system_condition_flags);
    start = 1'b1;
    pc_in = pc;
    @(negedge clock);
    start = 1'b0;
    check(busy_ff, 1'b1);
    c = 1;
    while (done_ff !== 1'b1 && c < 20) begin
      @(negedge clock);
      c++;
    end
    check(c, edges);
    check(busy_ff, 1'b0);
    check(illegal_ff, bad);
    check(wr_ff, !bad);
    if (bad) begin
      check(res_acc_ff, last_acc);
    end else begin
      check(res_acc_ff, e[15:8]);
      check(res_flags_ff, e[7:0]);
      check(len_ff, edges - 1);
      check(pc_ff, pc + nb[15:0]);
      last_acc = e[15:8];
    end
    if (use_mem) begin
      check(mem.last_daddr, da);
      check(mem.last_dpage, dp);
      check(mem.n_dreads - nd, 1);
    end
    pc = pc + nb[15:0];
  endtask : run

  initial begin
    #(25 * 4000);
    n_errors++;
    final_report();
  end

  initial begin
    logic [7:0] pg_ep, pg_xp, pg_yp;
    n_errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    start = 1'b0;
    banked = 1'b0;
    pc_in = 16'h0000;
    pc = 16'h0100;
    last_acc = 8'h00;
    regs = '0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      regs.acc = ta[i];
      regs.data_b = tb[i];
      // Stale N, V and Z are set on entry so the result must overwrite them
      regs.system_condition_flags = {2'b10, tm[i][2], tm[i][1], 2'b11, tm[i][0], 1'b1};
      run(OP_ADC_A_B, 8'h00, 8'h00, 1, 3, 1'b0, 16'h0000, 8'h00, 1'b0); // register source
      check(res_acc_ff, tr[i]); // example results
      check({res_flags_ff.negative, res_flags_ff.overflow, res_flags_ff.carry, res_flags_ff.zero}, tf[i]);
      check(res_flags_ff[7:4], {2'b10, tm[i][2], tm[i][1]}); // kept flags
    end
    regs.acc = 8'h99;
    regs.system_condition_flags = 8'h42;
    run(OP_ADC_A_A, 8'h00, 8'h00, 1, 3, 1'b0, 16'h0000, 8'h00, 1'b0); // self add
    regs.ptr_high = 8'h12;
    regs.ptr_low = 8'h80;
    regs.first_index_reg = 16'h0010;
    regs.second_index_reg = 16'hFFF0;
    regs.expand_page_data = 8'h21;
    regs.first_index_page = 8'h42;
    regs.second_index_page = 8'h63;
    for (int bk = 0; bk < 2; bk++) begin
      banked = bk[0];
      pg_ep = bk[0] ? 8'h21 : PAGE_FLAT;
      pg_xp = bk[0] ? 8'h42 : PAGE_FLAT;
      pg_yp = bk[0] ? 8'h63 : PAGE_FLAT;
      regs.acc = 8'h3C + bk[7:0];
      regs.system_condition_flags = {2'b01, 5'b00000, bk[0]};
      run(OP_ADC_PAIR, 8'h00, 8'h00, 1, 3, 1'b1, 16'h1280, pg_ep, 1'b0); // pair pointer
      run(OP_ADC_IDX1, 8'h00, 8'h00, 1, 3, 1'b1, 16'h0010, pg_xp, 1'b0); // first index
      run(OP_ADC_IDX2, 8'h00, 8'h00, 1, 3, 1'b1, 16'hFFF0, pg_yp, 1'b0); // second index
      run(OP_ADC_ABS, 8'h34, 8'hF2, 3, 5, 1'b1, 16'hF234, pg_ep, 1'b0); // absolute
      run(OP_PREFIX, SUB_DISP1, 8'h80, 3, 5, 1'b1, 16'hFF90, pg_xp, 1'b0); // negative offset
      run(OP_PREFIX, SUB_DISP2, 8'h7F, 3, 5, 1'b1, 16'h006F, pg_yp, 1'b0); // wrap forward
      run(OP_PREFIX, SUB_LOFS1, 8'h00, 2, 5, 1'b1, 16'hFF90, pg_xp, 1'b0); // low pointer offset
      run(OP_PREFIX, SUB_LOFS2, 8'h00, 2, 5, 1'b1, 16'hFF70, pg_yp, 1'b0); // low pointer offset
    end
    // Foreign codes finish without a result write
    run(8'h00, 8'h00, 8'h00, 1, 2, 1'b0, 16'h0000, 8'h00, 1'b1);
    run(OP_PREFIX, 8'hFF, 8'h00, 2, 3, 1'b0, 16'h0000, 8'h00, 1'b1);
    // Reset in the middle of an instruction leaves nothing pending
    mem.prog[pc] = OP_ADC_ABS;
    start = 1'b1;
    pc_in = pc;
    @(negedge clock);
    start = 1'b0;
    rst = 1'b1;
    @(negedge clock);
    check({busy_ff, done_ff, bus_rd_ff, res_acc_ff}, 11'h000);
    rst = 1'b0;
    @(negedge clock);
    check({busy_ff, done_ff, wr_ff}, 3'h0);
    run(OP_ADC_A_B, 8'h00, 8'h00, 1, 3, 1'b0, 16'h0000, 8'h00, 1'b0); // recovery after reset
    final_report();
  end
endmodule : add_with_carry_to_accumulator_test
